/* File: logic/wwd_consts.svh */
// timing counts and option defaults for the window watchdog supervisor
`ifndef WWD_CONSTS_SVH
`define WWD_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define CYC_PER_MS (1000000 / `CLK_PERIOD_NS)
`define CYC_PER_US (1000 / `CLK_PERIOD_NS)
`define FAULT_FAST_MS 50
`define FAULT_SLOW_MS 100
`define SLOW_FACTOR 10
`define OV_DELAY_US 5
`define OV_DELAY_CYC (`OV_DELAY_US * `CYC_PER_US)
`define CLR_LONG_US 5
`define CLR_LONG_CYC (`CLR_LONG_US * `CYC_PER_US)
`define CLR_MIN_NS 400
`define CLR_MIN_CYC ((`CLR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WD_OPTION_DEF 4
`define RST_OPTION_DEF 3
`endif

/* File: logic/wwd_pkg.sv */
// types for the window watchdog supervisor
package wwd_pkg;
    typedef enum logic [2:0] {
        RST_HOLD = 3'h1,
        RST_COUNT = 3'h2,
        RST_FREE = 3'h4
    } rst_state_e;
    typedef logic [31:0] count_t;
endpackage : wwd_pkg

/* File: logic/pin_sync.sv */
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_i, // clock
    input wire logic nrst_i, // async reset, active low
    input wire logic [WIDTH-1:0] async_i, // raw pins
    output logic [WIDTH-1:0] sync_o // synchronised levels
);
    logic [WIDTH-1:0] meta_reg;
    // reset value is all ones: pins idle high
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_reg <= '1;
            sync_o <= '1;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule : pin_sync

/* File: logic/window_watchdog_supervisor.sv */
// window watchdog, reset generator and latched overvoltage flag
// Behaviour
// R01: interval timer restarts on falling strobe edge and reset release
// R02: edge before fast limit gives 50 ms low fault pulse
// R03: no edge before slow limit gives 100 ms low fault pulse
// R04: edge inside window only restarts the timer
// R05: processor must strobe within the window
// R06: fast limit power of two 1..4096 ms, slow limit ten times
// R07: reset hold period chosen from fifteen values 1..1500 ms
// R08: reset goes low at once when supply leaves window
// R09: reset held for hold period after supply returns, restart if it leaves
// R10: overvoltage flag latches low 5 us after indication, stays low
// R11: clear pulse of minimum width releases flag once overvoltage gone
// R12: clear activity ignored while overvoltage present
// R13: clear held low over 5 us also asserts reset with hold period
// R14: long clear pulses need high gaps over the hold period
// R15: under supply lockout only reset is driven low; fault and flag are held high
// R16: clear must be low at least 0.4 us to release flag
// R17: after fault, strobe pulses must last at least 24 us
// R18: strobe timing shifted by synchroniser, a few cycles
// R19: slow fault with silence ends pulse and restarts timer
// R20: window and hold options are build-time parameters
`timescale 1ns/1ps
`include "wwd_consts.svh"
module window_watchdog_supervisor #(
    parameter int WD_OPTION = `WD_OPTION_DEF, // 1..13
    parameter int RST_OPTION = `RST_OPTION_DEF, // 1..15
    parameter int CYC_PER_MS = `CYC_PER_MS // shorten for simulation
) (
    input wire logic ref_clk_i, // 100 MHz oscillator
    input wire logic nrst_i, // async reset, active low
    input wire logic lockout_i, // supply below lockout threshold
    input wire logic in_window_i, // comparator: supply in window
    input wire logic overvoltage_i, // comparator: over threshold
    input wire logic watchdog_strobe_in_i, // strobe pin
    input wire logic fault_clear_in_n_i, // clear pin, active low
    output logic watchdog_fault_out_n_o, // fault, active low
    output logic reset_out_n_o, // reset, active low
    output logic overvoltage_flag_out_n_o // latched flag, active low
);
    // ------------------------------------------------------------
    // option tables
    // ------------------------------------------------------------
    function automatic wwd_pkg::count_t hold_ms(input int opt);
        case (opt)
            1: hold_ms = 1;
            2: hold_ms = 5;
            3: hold_ms = 10;
            4: hold_ms = 15;
            5: hold_ms = 20;
            6: hold_ms = 50;
            7: hold_ms = 100;
            8: hold_ms = 150;
            9: hold_ms = 200;
            10: hold_ms = 250;
            11: hold_ms = 300;
            12: hold_ms = 500;
            13: hold_ms = 750;
            14: hold_ms = 1000;
            default: hold_ms = 1500;
        endcase
    endfunction : hold_ms

    localparam wwd_pkg::count_t FAST_MS =
        32'h0000_0001 << (WD_OPTION - 1); // R06
    localparam wwd_pkg::count_t FAST_CYC = FAST_MS * CYC_PER_MS;
    localparam wwd_pkg::count_t SLOW_CYC = FAST_CYC * `SLOW_FACTOR; // R06
    localparam wwd_pkg::count_t HOLD_CYC =
        hold_ms(RST_OPTION) * CYC_PER_MS; // R07 R20
    localparam wwd_pkg::count_t PF_CYC = `FAULT_FAST_MS * CYC_PER_MS;
    localparam wwd_pkg::count_t PS_CYC = `FAULT_SLOW_MS * CYC_PER_MS;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pins_sync;
    pin_sync #(.WIDTH(2)) u_sync (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .async_i({watchdog_strobe_in_i, fault_clear_in_n_i}),
        .sync_o(pins_sync)
    ); // R18
    logic strobe_s, clear_n_s, strobe_d_reg;
    assign strobe_s = pins_sync[1];
    assign clear_n_s = pins_sync[0];

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) strobe_d_reg <= 1'b1;
        else strobe_d_reg <= strobe_s;
    end
    logic strobe_fall;
    assign strobe_fall = strobe_d_reg && !strobe_s;

    // ------------------------------------------------------------
    // overvoltage flag and clear input
    // ------------------------------------------------------------
    wwd_pkg::count_t ov_cnt_reg, clr_cnt_reg;
    logic ov_latched_reg, clr_long_reg;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) ov_cnt_reg <= '0;
        else if (!overvoltage_i) ov_cnt_reg <= '0;
        else if (ov_cnt_reg < `OV_DELAY_CYC) ov_cnt_reg <= ov_cnt_reg + 1;
    end
    // clear low time counted only outside overvoltage
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) clr_cnt_reg <= '0;
        else if (clear_n_s || overvoltage_i) clr_cnt_reg <= '0; // R12
        else if (clr_cnt_reg <= `CLR_LONG_CYC) clr_cnt_reg <= clr_cnt_reg + 1;
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) clr_long_reg <= 1'b0;
        else clr_long_reg <= (clr_cnt_reg > `CLR_LONG_CYC - 1); // R13
    end
    logic ov_set;
    assign ov_set = overvoltage_i && (ov_cnt_reg >= `OV_DELAY_CYC - 1);
    // set wins over clear; clear needs condition gone
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) ov_latched_reg <= 1'b0;
        else if (ov_set) ov_latched_reg <= 1'b1; // R10
        else if (!overvoltage_i && clr_cnt_reg >= `CLR_MIN_CYC - 1 &&
                 !clear_n_s)
            ov_latched_reg <= 1'b0; // R11 R16
    end

    // ------------------------------------------------------------
    // reset generator
    // ------------------------------------------------------------
    wwd_pkg::rst_state_e rst_state_reg;
    wwd_pkg::count_t hold_cnt_reg;
    logic rst_cause;
    assign rst_cause = !in_window_i || clr_long_reg;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_state_reg <= wwd_pkg::RST_HOLD;
            hold_cnt_reg <= '0;
        end else if (rst_cause) begin
            rst_state_reg <= wwd_pkg::RST_HOLD; // R08 R13
            hold_cnt_reg <= '0;
        end else begin
            case (rst_state_reg)
                wwd_pkg::RST_HOLD: begin
                    rst_state_reg <= wwd_pkg::RST_COUNT;
                    hold_cnt_reg <= '0;
                end
                wwd_pkg::RST_COUNT: begin
                    if (hold_cnt_reg >= HOLD_CYC - 2)
                        rst_state_reg <= wwd_pkg::RST_FREE; // R09
                    else hold_cnt_reg <= hold_cnt_reg + 1;
                end
                wwd_pkg::RST_FREE: rst_state_reg <= wwd_pkg::RST_FREE;
                default: rst_state_reg <= wwd_pkg::RST_HOLD;
            endcase
        end
    end
    logic rst_free;
    assign rst_free = (rst_state_reg == wwd_pkg::RST_FREE);
    logic rst_free_d_reg;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) rst_free_d_reg <= 1'b0;
        else rst_free_d_reg <= rst_free;
    end

    // ------------------------------------------------------------
    // window watchdog
    // ------------------------------------------------------------
    wwd_pkg::count_t wd_cnt_reg, pulse_cnt_reg;
    logic wd_fault_reg;
    logic slow_expire;
    assign slow_expire = (wd_cnt_reg >= SLOW_CYC) && !wd_fault_reg;
    // timer runs only while reset is released
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) wd_cnt_reg <= '0;
        else if (!rst_free || (rst_free && !rst_free_d_reg))
            wd_cnt_reg <= '0; // R01
        else if (strobe_fall) wd_cnt_reg <= '0; // R01 R04
        else if (wd_fault_reg && pulse_cnt_reg == 32'h0000_0001)
            wd_cnt_reg <= '0; // R19
        else if (!slow_expire && wd_cnt_reg < SLOW_CYC)
            wd_cnt_reg <= wd_cnt_reg + 1;
    end
    // a strobe during a pulse is not rejudged; limits the 24 us hazard
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wd_fault_reg <= 1'b0;
            pulse_cnt_reg <= '0;
        end else if (!rst_free) begin
            wd_fault_reg <= 1'b0;
            pulse_cnt_reg <= '0;
        end else if (wd_fault_reg) begin
            if (pulse_cnt_reg == 32'h0000_0001) wd_fault_reg <= 1'b0;
            pulse_cnt_reg <= pulse_cnt_reg - 1;
        end else if (strobe_fall && wd_cnt_reg < FAST_CYC) begin
            wd_fault_reg <= 1'b1; // R02
            pulse_cnt_reg <= PF_CYC;
        end else if (slow_expire) begin
            wd_fault_reg <= 1'b1; // R03 R19
            pulse_cnt_reg <= PS_CYC;
        end
    end

    // ------------------------------------------------------------
    // outputs under lockout
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reset_out_n_o <= 1'b0;
            watchdog_fault_out_n_o <= 1'b1;
            overvoltage_flag_out_n_o <= 1'b1;
        end else if (lockout_i) begin
            reset_out_n_o <= 1'b0; // R15
            watchdog_fault_out_n_o <= 1'b1;
            overvoltage_flag_out_n_o <= 1'b1;
        end else begin
            reset_out_n_o <= rst_free;
            watchdog_fault_out_n_o <= !wd_fault_reg;
            overvoltage_flag_out_n_o <= !(ov_latched_reg || ov_set);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    reset_low_a: assert property ( // R08
        @(posedge ref_clk_i) disable iff (!nrst_i)
        !in_window_i |=> ##1 !reset_out_n_o)
        else $error("reset not low after supply left window");
    hold_start_a: assert property ( // R09
        @(posedge ref_clk_i) disable iff (!nrst_i)
        rst_cause ##1 !rst_cause |=> !rst_free [*2])
        else $error("reset released too soon");
    ov_latch_a: assert property ( // R10
        @(posedge ref_clk_i) disable iff (!nrst_i)
        ov_set |=> ov_latched_reg)
        else $error("flag did not latch");
    ov_keep_a: assert property ( // R12
        @(posedge ref_clk_i) disable iff (!nrst_i)
        overvoltage_i && ov_latched_reg |=> ov_latched_reg)
        else $error("flag cleared during overvoltage");
    clr_reset_a: assert property ( // R13
        @(posedge ref_clk_i) disable iff (!nrst_i)
        clr_long_reg |=> !rst_free)
        else $error("long clear did not force reset");
    fast_fault_a: assert property ( // R02
        @(posedge ref_clk_i) disable iff (!nrst_i)
        rst_free && !wd_fault_reg && strobe_fall && wd_cnt_reg < FAST_CYC
        |=> wd_fault_reg && pulse_cnt_reg == PF_CYC)
        else $error("fast fault pulse missing");
    slow_fault_a: assert property ( // R03
        @(posedge ref_clk_i) disable iff (!nrst_i)
        rst_free && slow_expire && !strobe_fall
        |=> wd_fault_reg && pulse_cnt_reg == PS_CYC)
        else $error("slow fault pulse missing");
    window_ok_a: assert property ( // R04
        @(posedge ref_clk_i) disable iff (!nrst_i)
        rst_free && !wd_fault_reg && strobe_fall && wd_cnt_reg >= FAST_CYC
        && wd_cnt_reg < SLOW_CYC |=> !wd_fault_reg && wd_cnt_reg == 0)
        else $error("in-window strobe misjudged");
    lockout_out_a: assert property ( // R15
        @(posedge ref_clk_i) disable iff (!nrst_i)
        lockout_i |=> !reset_out_n_o)
        else $error("lockout did not force reset");
endmodule : window_watchdog_supervisor

/* File: bench/strobe_host.sv */
// model of the processor strobing the watchdog pin
`timescale 1ns/1ps
module strobe_host #(
    parameter int LOW_CYC = 3
) (
    input wire logic ref_clk_i, // bench clock
    output logic strobe_o // strobe pin, driven high when idle
);
    // -------------------------------------------------------------
    // strobe generation
    // -------------------------------------------------------------
    // low phase kept short: a scaled window is far below 24 us
    initial begin
        strobe_o = 1'b1;
    end

    // edge spacing is gap plus LOW_CYC cycles
    task automatic strobe(input int gap);
        repeat (gap) @(negedge ref_clk_i);
        strobe_o = 1'b0;
        repeat (LOW_CYC) @(negedge ref_clk_i);
        strobe_o = 1'b1;
    endtask : strobe
endmodule : strobe_host

/* File: bench/testbench.sv */
// self-checking testbench for the window watchdog supervisor
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i;
    logic nrst_i;
    logic lockout_i;
    logic in_window_i;
    logic overvoltage_i;
    logic strobe;
    logic clear_n;
    logic fault_n;
    logic rst_n;
    logic flag_n;
    int error_cnt = 0;
    int tests_run = 0;
    int fault_low = 0;
    int at;
    int f0;

    // -------------------------------------------------------------
    // design and partner
    // -------------------------------------------------------------
    // fast 10, slow 100, hold 100 cycles (default hold option)
    window_watchdog_supervisor #(
        .WD_OPTION(1), .CYC_PER_MS(10)
    ) dut (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .lockout_i(lockout_i),
        .in_window_i(in_window_i),
        .overvoltage_i(overvoltage_i),
        .watchdog_strobe_in_i(strobe),
        .fault_clear_in_n_i(clear_n),
        .watchdog_fault_out_n_o(fault_n),
        .reset_out_n_o(rst_n),
        .overvoltage_flag_out_n_o(flag_n)
    );
    strobe_host host (.ref_clk_i(ref_clk_i), .strobe_o(strobe));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    always @(negedge ref_clk_i) begin
        if (fault_n === 1'b0) fault_low <= fault_low + 1;
    end

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %0d expected %0d",
                     $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : cyc

    task automatic wait_for(ref logic sig, input logic lvl, input int lim,
                            output int n);
        n = 0;
        while (sig !== lvl && n < lim) begin
            @(negedge ref_clk_i);
            n++;
        end
    endtask : wait_for

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_window_and_fast();
        f0 = fault_low;
        repeat (3) host.strobe(40);
        cyc(3);
        check(fault_low - f0, 0);
        host.strobe(1);
        wait_for(fault_n, 1'b0, 10, at);
        check(32'(at < 10), 1);
        // strobes during the pulse only restart the timer
        while (fault_n === 1'b0) host.strobe(40);
        cyc(5);
        check(fault_low - f0, 500);
    endtask : t_window_and_fast

    task automatic t_silence();
        f0 = fault_low;
        wait_for(fault_n, 1'b0, 200, at);
        check(32'(at >= 95 && at <= 108), 1);
        wait_for(fault_n, 1'b1, 2000, at);
        wait_for(fault_n, 1'b0, 200, at);
        check(32'(at >= 95 && at <= 108), 1);
        while (fault_n === 1'b0) host.strobe(40);
        cyc(5);
        check(fault_low - f0, 2000);
    endtask : t_silence

    task automatic t_supply();
        in_window_i = 1'b0;
        cyc(3);
        check(rst_n, 0);
        cyc(20);
        in_window_i = 1'b1;
        cyc(5);
        in_window_i = 1'b0;
        cyc(1);
        in_window_i = 1'b1;
        wait_for(rst_n, 1'b1, 200, at);
        check(32'(at >= 99 && at <= 105), 1);
    endtask : t_supply

    task automatic t_overvoltage();
        overvoltage_i = 1'b1;
        wait_for(flag_n, 1'b0, 600, at);
        check(32'(at >= 498 && at <= 505), 1);
        clear_n = 1'b0;
        cyc(600);
        clear_n = 1'b1;
        cyc(3);
        check(rst_n, 1);
        check(flag_n, 0);
        overvoltage_i = 1'b0;
        cyc(20);
        check(flag_n, 0);
        clear_n = 1'b0;
        cyc(40);
        clear_n = 1'b1;
        cyc(6);
        check(flag_n, 1);
        check(rst_n, 1);
        cyc(20);
        clear_n = 1'b0;
        cyc(520);
        check(rst_n, 0);
        clear_n = 1'b1;
        wait_for(rst_n, 1'b1, 200, at);
        check(32'(at >= 102 && at <= 108), 1);
    endtask : t_overvoltage

    task automatic t_lockout();
        overvoltage_i = 1'b1;
        lockout_i = 1'b1;
        cyc(600);
        check(rst_n, 0);
        check(fault_n, 1);
        check(flag_n, 1);
        overvoltage_i = 1'b0;
        lockout_i = 1'b0;
        wait_for(rst_n, 1'b1, 40, at);
        check(32'(at <= 16), 1);
        check(flag_n, 0);
    endtask : t_lockout

    // -------------------------------------------------------------
    // main sequence and watchdog
    // -------------------------------------------------------------
    initial begin
        nrst_i = 1'b0;
        lockout_i = 1'b0;
        in_window_i = 1'b1;
        overvoltage_i = 1'b0;
        clear_n = 1'b1;
        cyc(4);
        nrst_i = 1'b1;
        cyc(1);
        check(rst_n, 0);
        wait_for(rst_n, 1'b1, 200, at);
        check(32'(at >= 98 && at <= 106), 1);
        t_window_and_fast();
        t_silence();
        t_supply();
        t_overvoltage();
        t_lockout();
        stop_test();
    end

    // whole run needs about 5600 cycles
    initial begin
        cyc(30000);
        error_cnt++;
        $display("wrong value at %0t: run did not finish", $time);
        stop_test();
    end
endmodule : testbench
